// ---- logic/frpc_ctrl.v ----
// Data rate, write gate timing, low power and reset control of the floppy controller
`timescale 1ns/100ps
`include "frpc_defines.vh"

// Notes on behaviour
// - Perpendicular 1 Mbps: gate 38 bytes early
// - Perpendicular 1 Mbps gap 2 is 41
// - Perpendicular mode adjusts parameters at 500 kbps and 1 Mbps only
// - Config register low two bits set rate
// - Rate-select low two bits set rate too
// - Last written rate wins; clocks scale
// - Power-up default precomp, start track zero
// - Precomp delay and start track programmable
// - Power-down clears host_may_transfer flag
// - Registers kept and accessible while powered down
// - Rate-select bit 6 powers down, self-clears
// - Manual power-down is OR of sources
// - Auto low power 500 ms after idle
// - Auto low power armed only by mode
// - Software reset wakes from power-down
// - Status or FIFO access wakes, keeps state
// - Master reset restores all defaults
// - Reset leaves specify values untouched
// - Soft reset via output bit 2/rate bit 7
// - Lock keeps configure and mode FIFO fields
// - Status reads 00h then 80h within 250us
module frpc_ctrl #(
  parameter AUTO_CYC  = `FRPC_AUTO_CYC,  // Idle time before automatic low power
  parameter STAB_CYC  = `FRPC_STAB_CYC,  // Clock stabilisation time after wake
  parameter READY_CYC = `FRPC_READY_CYC  // Reset to ready time
) (
  input  wire        mclk,               // 200 MHz clock
  input  wire        sys_rst,            // Synchronous reset, active high
  input  wire        clk_en,             // Freezes all state while low
  input  wire        master_reset_pin,   // Master reset pin, asynchronous source
  input  wire [2:0]  reg_addr,           // Register offset
  input  wire [7:0]  reg_wdata,          // Write data
  input  wire        reg_wr,             // Write strobe, one cycle
  input  wire        reg_rd,             // Read strobe, one cycle
  output reg  [7:0]  reg_rdata,          // Read data
  input  wire        cmd_mode,           // Mode command strobe
  input  wire        cmd_power_down_option, // Mode command low-power option
  input  wire        cmd_auto_arm,       // Mode command arms automatic low power
  input  wire        cmd_fifo_write_disable, // Mode command field
  input  wire        cmd_fifo_read_disable,  // Mode command field
  input  wire        cmd_burst_disable,  // Mode command field
  input  wire        cmd_configure,      // Configure command strobe
  input  wire        cmd_fifo_disable,   // Configure FIFO disable field
  input  wire [3:0]  cmd_fifo_threshold, // Configure threshold field
  input  wire [7:0]  cmd_precomp_start_track, // Configure start track field
  input  wire        cmd_lock,           // Lock command strobe
  input  wire        cmd_lock_value,     // Lock value
  input  wire        cmd_perp,           // Perpendicular mode command strobe
  input  wire        cmd_perp_value,     // Perpendicular enable value
  input  wire        engine_idle,        // Micro-engine is in idle
  input  wire        engine_busy_status, // Engine status for main status bit 0
  output reg  [1:0]  data_rate,          // Active data rate code
  output reg  [2:0]  precomp_delay,      // Write precompensation delay code
  output reg  [7:0]  precomp_start_track,// Precomp start track
  output reg  [7:0]  gap2_len,           // Gap 2 length in bytes
  output reg  [7:0]  write_gate_lead,    // Bytes write_gate leads the preamble
  output reg         perp_mode,          // Perpendicular mode active
  output reg         fifo_disable,       // FIFO disabled
  output reg  [3:0]  fifo_threshold,     // FIFO threshold
  output reg         fifo_write_disable, // FIFO write disable
  output reg         fifo_read_disable,  // FIFO read disable
  output reg         burst_disable,      // Burst disable
  output reg  [7:0]  digital_output_reg, // Drive select, motors, DMA, reset bits
  output reg         powered_down,       // Engine and separator clocks stopped
  output reg         soft_reset,         // Engine held in reset
  output reg         host_may_transfer   // Main status bit 7
);

  reg        mr_s1;
  reg        mr_s2;
  reg        dsr_pwr;
  reg        mode_pwr;
  reg        auto_armed;
  reg        dsr_rst;
  reg        was_idle;
  reg [31:0] auto_cnt;
  reg [31:0] stab_cnt;
  reg [31:0] rdy_cnt;
  reg        stab_wait;
  reg        rdy_wait;
  reg        lock;
  reg        auto_run;
  reg        next_host_may_transfer;

  wire hw_rst    = sys_rst | mr_s2;
  wire wr_dsr    = reg_wr & (reg_addr == `FRPC_OFS_DSR);
  wire wr_ccr    = reg_wr & (reg_addr == `FRPC_OFS_CCR);
  wire wr_dor    = reg_wr & (reg_addr == `FRPC_OFS_DOR);
  wire msr_rd    = reg_rd & (reg_addr == `FRPC_OFS_MSR);
  wire fifo_acc  = (reg_wr | reg_rd) & (reg_addr == `FRPC_OFS_FIFO);
  // Writes to offset 4 land in the rate-select register and wake only through its soft-reset bit 7
  wire host_acc  = msr_rd | fifo_acc;
  wire dsr_pd_wr = wr_dsr & reg_wdata[`FRPC_DSR_PWRDN_BIT];
  wire new_dsr_rst = wr_dsr & reg_wdata[`FRPC_DSR_SWRST_BIT];
  wire new_dor_rst = wr_dor & reg_wdata[`FRPC_DOR_SWRST_BIT];
  wire sw_rst_evt  = new_dsr_rst | new_dor_rst;
  wire in_sw_rst   = dsr_rst | digital_output_reg[`FRPC_DOR_SWRST_BIT];
  wire wake_evt    = powered_down & (host_acc | sw_rst_evt);
  wire pwr_req     = dsr_pwr | mode_pwr;
  wire idle_entry  = engine_idle & !was_idle;

  always @(posedge mclk) begin
    if (sys_rst) begin
      mr_s1 <= 1'b0;
      mr_s2 <= 1'b0;
    end else if (clk_en) begin
      mr_s1 <= master_reset_pin;
      mr_s2 <= mr_s1;
    end
  end

  // Specify values live outside; no reset reaches them here
  always @(posedge mclk) begin
    if (hw_rst) begin
      data_rate           <= `FRPC_RATE_RESET;
      precomp_delay       <= `FRPC_PRECOMP_RESET;
      perp_mode           <= 1'b0;
      digital_output_reg  <= `FRPC_DOR_RESET;
      lock                <= 1'b0;
      dsr_rst             <= 1'b0;
    end else if (clk_en) begin
      // Rate registers stay writable while powered down
      if (wr_dsr) begin
        data_rate     <= reg_wdata[1:0];
        precomp_delay <= reg_wdata[4:2];
      end else if (wr_ccr) begin
        data_rate <= reg_wdata[1:0];
      end
      if (wr_dor)
        digital_output_reg <= reg_wdata;
      dsr_rst <= new_dsr_rst;
      if (cmd_lock)
        lock <= cmd_lock_value;
      if (cmd_perp)
        perp_mode <= cmd_perp_value;
      if (in_sw_rst)
        perp_mode <= 1'b0;
    end
  end

  // Fields kept across a soft reset while locked
  always @(posedge mclk) begin
    if (hw_rst) begin
      fifo_disable        <= 1'b1;
      fifo_threshold      <= `FRPC_FIFO_THRESHOLD_RESET;
      precomp_start_track <= `FRPC_PRECOMP_START_TRACK_RESET;
      fifo_write_disable  <= 1'b1;
      fifo_read_disable   <= 1'b1;
      burst_disable       <= 1'b1;
    end else if (clk_en) begin
      if (in_sw_rst && !lock) begin
        fifo_disable        <= 1'b1;
        fifo_threshold      <= `FRPC_FIFO_THRESHOLD_RESET;
        precomp_start_track <= `FRPC_PRECOMP_START_TRACK_RESET;
        fifo_write_disable  <= 1'b1;
        fifo_read_disable   <= 1'b1;
        burst_disable       <= 1'b1;
      end else begin
        if (cmd_configure) begin
          fifo_disable        <= cmd_fifo_disable;
          fifo_threshold      <= cmd_fifo_threshold;
          precomp_start_track <= cmd_precomp_start_track;
        end
        if (cmd_mode) begin
          fifo_write_disable <= cmd_fifo_write_disable;
          fifo_read_disable  <= cmd_fifo_read_disable;
          burst_disable      <= cmd_burst_disable;
        end
      end
    end
  end

  // Manual and automatic low-power requests; a set wins over a wake
  always @(posedge mclk) begin
    if (hw_rst) begin
      dsr_pwr    <= 1'b0;
      mode_pwr   <= 1'b0;
      auto_armed <= 1'b0;
    end else if (clk_en) begin
      if (dsr_pd_wr)
        dsr_pwr <= 1'b1;
      else if (wake_evt)
        dsr_pwr <= 1'b0;
      if (cmd_mode) begin
        mode_pwr   <= cmd_power_down_option;
        auto_armed <= cmd_auto_arm;
      end else if (wake_evt) begin
        mode_pwr <= 1'b0;
      end
    end
  end

  // Flag is held low by every reason the host must not issue a command
  always @* begin
    next_host_may_transfer = 1'b1;
    if (powered_down | pwr_req | dsr_pd_wr)
      next_host_may_transfer = 1'b0;
    if (wake_evt | stab_wait)
      next_host_may_transfer = 1'b0;
    if (rdy_wait | in_sw_rst)
      next_host_may_transfer = 1'b0;
  end

  // Gap 2 and write gate lead follow the rate in perpendicular mode
  always @(posedge mclk) begin
    if (hw_rst) begin
      gap2_len        <= `FRPC_GAP2_STD;
      write_gate_lead <= 8'h00;
    end else if (clk_en) begin
      if (perp_mode && data_rate == `FRPC_RATE_1M) begin
        gap2_len        <= `FRPC_GAP2_PERP;
        write_gate_lead <= `FRPC_PREERASE_1M;
      end else if (perp_mode && data_rate == `FRPC_RATE_500K) begin
        gap2_len        <= `FRPC_GAP2_STD;
        write_gate_lead <= `FRPC_PREERASE_500K;
      end else begin
        gap2_len        <= `FRPC_GAP2_STD;
        write_gate_lead <= 8'h00;
      end
    end
  end

  // Power state, auto low-power timer, wake and ready timing
  always @(posedge mclk) begin
    if (hw_rst) begin
      powered_down      <= 1'b0;
      was_idle          <= 1'b0;
      auto_cnt          <= 32'h00000000;
      auto_run          <= 1'b0;
      stab_wait         <= 1'b0;
      stab_cnt          <= 32'h00000000;
      rdy_wait          <= 1'b1;
      rdy_cnt           <= 32'h00000000;
      soft_reset        <= 1'b0;
      host_may_transfer <= 1'b0;
    end else if (clk_en) begin
      was_idle   <= engine_idle;
      soft_reset <= in_sw_rst;
      if (wake_evt) begin
        powered_down <= 1'b0;
        stab_wait    <= 1'b1;
        stab_cnt     <= 32'h00000000;
      end else if (!powered_down && (pwr_req || dsr_pd_wr)) begin
        // The rate-select bit takes effect on the write edge itself
        powered_down <= 1'b1;
      end else if (!powered_down && auto_armed && engine_idle && auto_run &&
                   auto_cnt == AUTO_CYC - 1) begin
        powered_down <= 1'b1;
      end
      // Timer runs once per entry into idle; a wake while idle does not rearm it
      if (!engine_idle || powered_down) begin
        auto_run <= 1'b0;
        auto_cnt <= 32'h00000000;
      end else if (idle_entry) begin
        auto_run <= 1'b1;
        auto_cnt <= 32'h00000000;
      end else if (auto_run && auto_cnt != AUTO_CYC - 1) begin
        auto_cnt <= auto_cnt + 32'h00000001;
      end
      if (stab_wait) begin
        if (stab_cnt == STAB_CYC - 1)
          stab_wait <= 1'b0;
        else
          stab_cnt <= stab_cnt + 32'h00000001;
      end
      // Ready countdown restarts for as long as a soft reset is held
      if (in_sw_rst) begin
        rdy_wait <= 1'b1;
        rdy_cnt  <= 32'h00000000;
      end else if (rdy_wait) begin
        if (rdy_cnt == READY_CYC - 1)
          rdy_wait <= 1'b0;
        else
          rdy_cnt <= rdy_cnt + 32'h00000001;
      end
      host_may_transfer <= next_host_may_transfer;
    end
  end

  // Main status and output register readable at all times; other offsets answer zero
  always @(posedge mclk) begin
    if (hw_rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_rd && reg_addr == `FRPC_OFS_MSR)
        reg_rdata <= {host_may_transfer, 6'h00,
                      engine_busy_status & host_may_transfer};
      else if (reg_rd && reg_addr == `FRPC_OFS_DOR)
        reg_rdata <= digital_output_reg;
      else if (reg_rd)
        reg_rdata <= 8'h00;
    end
  end

endmodule // frpc_ctrl

// ---- logic/frpc_defines.vh ----
// Offsets, field positions, reset values and timing counts of the rate/power/reset control
`ifndef FRPC_DEFINES_VH
`define FRPC_DEFINES_VH
`define FRPC_OFS_DOR        3'h2
`define FRPC_OFS_MSR        3'h4
`define FRPC_OFS_DSR        3'h4
`define FRPC_OFS_FIFO       3'h5
`define FRPC_OFS_CCR        3'h7
`define FRPC_DOR_SWRST_BIT  2
`define FRPC_DSR_PWRDN_BIT  6
`define FRPC_DSR_SWRST_BIT  7
`define FRPC_MSR_RQM_BIT    7
`define FRPC_RATE_RESET     2'h0
`define FRPC_RATE_500K      2'h0
`define FRPC_RATE_1M        2'h3
`define FRPC_PRECOMP_RESET  3'h0
`define FRPC_PRECOMP_START_TRACK_RESET   8'h00
`define FRPC_FIFO_THRESHOLD_RESET   4'h0
`define FRPC_DOR_RESET      8'h00
`define FRPC_GAP2_STD       8'h16
`define FRPC_GAP2_PERP      8'h29
`define FRPC_PREERASE_1M    8'h26
`define FRPC_PREERASE_500K  8'h13
`define FRPC_CLK_MHZ        200
`define FRPC_READY_US       250
`define FRPC_READY_CYC      ((`FRPC_READY_US * `FRPC_CLK_MHZ) - 1)
`define FRPC_AUTO_MS        500
`define FRPC_AUTO_CYC       (`FRPC_AUTO_MS * 1000 * `FRPC_CLK_MHZ)
`define FRPC_STAB_US        2000
`define FRPC_STAB_CYC       (`FRPC_STAB_US * `FRPC_CLK_MHZ)
`endif

// ---- verif/frpc_ctrl_props.sv ----
// Checker for rate, power-down and ready relations of the control block
`timescale 1ns/100ps
module frpc_ctrl_props #(
  parameter READY_CYC = 10  // Reset to ready time
) (
  input logic       mclk,              // Clock
  input logic       sys_rst,           // Reset
  input logic [2:0] reg_addr,          // Offset
  input logic [7:0] reg_wdata,         // Write data
  input logic       reg_wr,            // Write strobe
  input logic       reg_rd,            // Read strobe
  input logic [7:0] reg_rdata,         // Read data
  input logic [1:0] data_rate,         // Rate code
  input logic [2:0] precomp_delay,     // Precomp code
  input logic [7:0] gap2_len,          // Gap 2
  input logic [7:0] write_gate_lead,   // Gate lead
  input logic       perp_mode,         // Perpendicular
  input logic       powered_down,      // Low power
  input logic       soft_reset,        // Soft reset
  input logic       host_may_transfer  // Ready flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  localparam int RDY_MAX = READY_CYC + 4;
  wire       dsr_wr  = reg_wr && reg_addr == 3'h4 && !reg_wdata[7];
  wire [1:0] wr_rate = reg_wdata[1:0];
  wire [2:0] wr_pre  = reg_wdata[4:2];
  sequence s_perp_1m; (perp_mode && data_rate == 2'h3) [*2]; endsequence
  sequence s_std; (!perp_mode) [*2]; endsequence
  a_rate_dsr: assert property (dsr_wr |=> data_rate == $past(wr_rate))
    else $error("rate not taken from rate select write");
  a_rate_cfg: assert property (reg_wr && reg_addr == 3'h7 |=> data_rate == $past(wr_rate))
    else $error("rate not taken from config write");
  a_precomp_set: assert property (dsr_wr |=> precomp_delay == $past(wr_pre))
    else $error("precomp delay not taken");
  a_gap_perp: assert property (s_perp_1m |-> gap2_len == 8'h29 && write_gate_lead == 8'h26)
    else $error("perpendicular gap or gate lead wrong");
  a_gap_std: assert property (s_std |-> gap2_len == 8'h16 && write_gate_lead == 8'h00)
    else $error("standard gap or gate lead wrong");
  a_pd_entry: assert property (dsr_wr && reg_wdata[6] |=> powered_down ##1 !host_may_transfer)
    else $error("power-down entry wrong");
  a_wake_access: assert property (powered_down && reg_rd && (reg_addr == 3'h4 || reg_addr == 3'h5)
    |=> !powered_down && !host_may_transfer)
    else $error("access did not wake");
  a_stab_hold: assert property ($fell(powered_down) |-> !host_may_transfer [*8])
    else $error("flag high before clock stable");
  a_rst_low: assert property ($fell(sys_rst) |-> !host_may_transfer [*8])
    else $error("flag high too early after reset");
  a_rst_ready: assert property ($fell(sys_rst) |-> ##[1:RDY_MAX] host_may_transfer)
    else $error("flag late after reset");
  a_soft_low: assert property ($rose(soft_reset) |=> !host_may_transfer [*4])
    else $error("flag high during soft reset");
  a_status_read: assert property (reg_rd && reg_addr == 3'h4 && !powered_down
    |=> {reg_rdata[7], reg_rdata[6:1]} == {$past(host_may_transfer), 6'h00})
    else $error("status read value wrong");
endmodule // frpc_ctrl_props
bind frpc_ctrl frpc_ctrl_props #(.READY_CYC(READY_CYC)) frpc_ctrl_props_inst (.*);

// ---- verif/frpc_host_model.sv ----
// Host processor model driving the byte-wide register strobes
`timescale 1ns/100ps
module frpc_host_model (
  input  logic       mclk,      // Clock, never removed
  output logic [2:0] reg_addr,  // Offset
  output logic [7:0] reg_wdata, // Write data
  output logic       reg_wr,    // Write strobe
  output logic       reg_rd,    // Read strobe
  input  logic [7:0] reg_rdata  // Read data
);
  initial begin
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Released data is inverted so stale values never look valid
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= (a == 3'h7) ? {6'h00, d[1:0]} : d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule // frpc_host_model

// ---- verif/tb.sv ----
// Self-checking bench for the rate, power-down and reset control
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error at %0t: got %h want %h", $time, a, b); end end
module tb;
  logic mclk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, master_reset_pin = 1'b0;
  logic cmd_mode = 1'b0, cmd_power_down_option = 1'b0, cmd_auto_arm = 1'b0;
  logic cmd_fifo_write_disable = 1'b0, cmd_fifo_read_disable = 1'b0, cmd_burst_disable = 1'b0;
  logic cmd_configure = 1'b0, cmd_fifo_disable = 1'b0, cmd_lock = 1'b0, cmd_lock_value = 1'b0;
  logic cmd_perp = 1'b0, cmd_perp_value = 1'b0, engine_idle = 1'b0, engine_busy_status = 1'b0;
  logic [3:0] cmd_fifo_threshold = 4'h0;
  logic [7:0] cmd_precomp_start_track = 8'h00;
  wire  [7:0] reg_wdata, reg_rdata, precomp_start_track, gap2_len, write_gate_lead;
  wire  [7:0] digital_output_reg;
  wire  [3:0] fifo_threshold;
  wire  [2:0] reg_addr, precomp_delay;
  wire  [1:0] data_rate;
  wire        reg_wr, reg_rd, perp_mode, fifo_disable, fifo_write_disable, fifo_read_disable;
  wire        burst_disable, powered_down, soft_reset, host_may_transfer;
  int         error_cnt = 0, check_count = 0, exp_rate = 0, exp_pre = 0, n;
  logic [31:0] seed = 32'hc4a1;
  logic [7:0]  d;
  frpc_ctrl #(.AUTO_CYC(20), .STAB_CYC(10), .READY_CYC(10)) frpc_ctrl_inst (.*);
  frpc_host_model frpc_host_model_inst (.*);
  always #2.5 mclk = ~mclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic complete_run;
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wrs(input logic [2:0] a, input logic [7:0] v);
    frpc_host_model_inst.wr(a, v);
    repeat (2) @(posedge mclk);
    #1;
  endtask
  // Strobe order {mode, configure, lock, perpendicular}
  task automatic cmd(input logic [3:0] k);
    @(posedge mclk);
    {cmd_mode, cmd_configure, cmd_lock, cmd_perp} <= k;
    @(posedge mclk);
    {cmd_mode, cmd_configure, cmd_lock, cmd_perp} <= 4'h0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic ready;
    for (n = 0; host_may_transfer !== 1'b1 && n < 40; n++) begin
      @(posedge mclk);
      #1;
    end
    #1 `CHK(n <= 16, 1'b1)
  endtask
  task automatic wait_pd;
    for (n = 0; powered_down !== 1'b1 && n < 60; n++) begin
      @(posedge mclk);
      #1;
    end
    `CHK(n >= 15 && n <= 26, 1'b1)
  endtask
  task automatic defaults;
    `CHK({data_rate, precomp_delay, precomp_start_track}, 13'h0000)
    `CHK({fifo_disable, fifo_threshold, fifo_write_disable, fifo_read_disable,
      burst_disable}, 8'h87)
    `CHK({digital_output_reg, perp_mode, powered_down, host_may_transfer}, 11'h000)
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge mclk);
    #1 defaults;
    @(posedge mclk) sys_rst <= 1'b0;
    ready;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      if (seed[8]) begin
        wrs(3'h4, {3'h0, seed[4:0]});
        exp_pre = seed[4:2];
      end else
        wrs(3'h7, seed[7:0]);
      exp_rate = seed[1:0];
      `CHK(data_rate, exp_rate[1:0])
      `CHK(precomp_delay, exp_pre[2:0])
    end
    `CHK(powered_down, 1'b0)
    @(posedge mclk) cmd_perp_value <= 1'b1;
    cmd(4'b0001);
    for (int r = 0; r < 4; r++) begin
      wrs(3'h7, 8'(r));
      `CHK(gap2_len, (r == 3) ? 8'h29 : 8'h16)
      `CHK(write_gate_lead, (r == 3) ? 8'h26 : (r == 0) ? 8'h13 : 8'h00)
    end
    @(posedge mclk) {cmd_fifo_write_disable, cmd_fifo_read_disable, cmd_burst_disable} <= 3'b101;
    @(posedge mclk) {cmd_precomp_start_track, cmd_fifo_threshold, cmd_lock_value} <= 13'h0AF;
    cmd(4'b1110);
    wrs(3'h4, 8'h80);
    `CHK({perp_mode, fifo_disable, fifo_threshold, precomp_start_track}, 14'h0705)
    `CHK({fifo_write_disable, fifo_read_disable, burst_disable}, 3'b101)
    ready;
    frpc_host_model_inst.rd(3'h4, d);
    `CHK(d, 8'h80)
    wrs(3'h2, 8'h00);
    wrs(3'h4, 8'h40);
    `CHK({powered_down, host_may_transfer}, 2'b10)
    wrs(3'h7, 8'h02);
    `CHK(data_rate, 2'h2)
    wrs(3'h4, 8'h41);
    `CHK({powered_down, data_rate}, 3'b101)
    frpc_host_model_inst.rd(3'h4, d);
    `CHK(powered_down, 1'b0)
    ready;
    `CHK({powered_down, precomp_start_track}, 9'h005)
    @(posedge mclk) cmd_power_down_option <= 1'b1;
    cmd(4'b1000);
    `CHK(powered_down, 1'b1)
    @(posedge mclk) cmd_power_down_option <= 1'b0;
    frpc_host_model_inst.rd(3'h5, d);
    `CHK(powered_down, 1'b0)
    ready;
    @(posedge mclk) cmd_auto_arm <= 1'b1;
    cmd(4'b1000);
    @(posedge mclk) {cmd_auto_arm, engine_idle} <= 2'b01;
    wait_pd;
    frpc_host_model_inst.rd(3'h4, d);
    @(posedge mclk) engine_idle <= 1'b0;
    ready;
    @(posedge mclk) engine_idle <= 1'b1;
    wait_pd;
    @(posedge mclk) engine_idle <= 1'b0;
    wrs(3'h2, 8'h04);
    `CHK({powered_down, soft_reset}, 2'b01)
    wrs(3'h2, 8'h00);
    `CHK(soft_reset, 1'b0)
    ready;
    @(posedge mclk) master_reset_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 defaults;
    @(posedge mclk) master_reset_pin <= 1'b0;
    ready;
    complete_run;
  end
endmodule // tb
